//--- hw/swcfg_device.sv
// device end: switch setup registers and per-port transmit level advertisement
// assumes the host holds req until ack; straps are asynchronous pins
`timescale 1ns/1ps
module swcfg_device (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CE,
  // link to host
  swcfg_link.dev LINK,
  // strap pins, active low high-level enable
  input wire logic [1:0] TX_LEVEL_STRAP_N,
  // link partner advertisement from negotiation logic
  input wire logic [1:0] LP_ABL,
  input wire logic [1:0] LP_REQ,
  input wire logic [1:0] AN_DONE,
  // switch configuration outputs
  output logic SETUP_DONE,
  output logic [1:0] CHUNK_SIZE,
  output logic CUT_THROUGH,
  output logic PORT1_UNKNOWN_TO_PORT2_EN,
  output logic PORT2_UNKNOWN_TO_PORT1_EN,
  output logic PORT1_UNKNOWN_TO_HOST_EN,
  output logic PORT2_UNKNOWN_TO_HOST_EN,
  output logic [15:0] IRQ_SOURCE_MASK,
  output logic [15:0] IRQ_PIN_MASK,
  // per-port advertisement and result
  output logic [1:0] HV_TX_ABILITY,
  output logic [1:0] ADV_HV_ABILITY,
  output logic [1:0] ADV_HV_REQUEST,
  output logic [1:0] AN_ENABLE,
  output logic [1:0] TX_LEVEL_HIGH
);
  // ----------------------------------------------------------------
  // strap synchroniser and latch
  // ----------------------------------------------------------------
  logic [1:0] strap_meta_reg, strap_sync_reg;
  logic [2:0] settle_reg, settle_next;
  logic [1:0] hv_tx_ability_flag, hv_flag_next;
  logic soft_rst_reg, soft_rst_next;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      strap_meta_reg <= 2'h0;
      strap_sync_reg <= 2'h0;
    end else if (CE) begin
      strap_meta_reg <= TX_LEVEL_STRAP_N;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // the flag stays 0 until the synchroniser has filled, so a stale
  // reset value can never grant the high level
  always_comb begin
    settle_next = settle_reg;
    hv_flag_next = hv_tx_ability_flag;
    if (soft_rst_reg) begin
      settle_next = swcfg_pkg::STRAP_SETTLE;
      hv_flag_next = 2'h0;
    end else if (settle_reg != 3'h0) begin
      settle_next = settle_reg - 3'h1;
      if (settle_reg == 3'h1) begin
        hv_flag_next = ~strap_sync_reg;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      settle_reg <= swcfg_pkg::STRAP_SETTLE;
      hv_tx_ability_flag <= 2'h0;
    end else if (CE) begin
      settle_reg <= settle_next;
      hv_tx_ability_flag <= hv_flag_next;
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [15:0] irq_source_mask_reg, irq_source_mask_next;
  logic [15:0] irq_pin_mask_reg, irq_pin_mask_next;
  logic [15:0] switch_setup_reg_a, switch_setup_a_next;
  logic [15:0] switch_setup_reg_b, switch_setup_b_next;
  logic [1:0] adv_hv_ability_bit, adv_abl_next;
  logic [1:0] adv_hv_request_bit, adv_req_next;
  logic [1:0] an_en_reg, an_en_next;
  logic ack_reg, ack_next;
  logic [15:0] rdata_reg, rdata_next;
  logic take;
  logic [3:0] port_idx;
  logic [3:0] port_off;

  assign take = LINK.req && !ack_reg;
  assign port_idx = LINK.addr[7:4];
  assign port_off = LINK.addr[3:0];

  always_comb begin
    irq_source_mask_next = irq_source_mask_reg;
    irq_pin_mask_next = irq_pin_mask_reg;
    switch_setup_a_next = switch_setup_reg_a;
    switch_setup_b_next = switch_setup_reg_b;
    adv_abl_next = adv_hv_ability_bit;
    adv_req_next = adv_hv_request_bit;
    an_en_next = an_en_reg;
    soft_rst_next = 1'b0;
    ack_next = take;
    rdata_next = rdata_reg;
    // an ability flag that drops to 0 later also drops what was advertised
    adv_abl_next = adv_abl_next & hv_tx_ability_flag;
    adv_req_next = adv_req_next & hv_tx_ability_flag;
    if (take) begin
      rdata_next = 16'h0000;
      if (LINK.we) begin
        case (LINK.addr)
          swcfg_pkg::A_IRQ_SRC: irq_source_mask_next = LINK.wdata;
          swcfg_pkg::A_IRQ_PIN: irq_pin_mask_next = LINK.wdata;
          swcfg_pkg::A_SETUP_A: begin
            switch_setup_a_next = LINK.wdata;
            switch_setup_a_next[swcfg_pkg::B_SOFT_RST] = 1'b0;
            soft_rst_next = LINK.wdata[swcfg_pkg::B_SOFT_RST];
          end
          swcfg_pkg::A_SETUP_B: switch_setup_b_next = LINK.wdata;
          default: begin
          end
        endcase
      end else begin
        case (LINK.addr)
          swcfg_pkg::A_IRQ_SRC: rdata_next = irq_source_mask_reg;
          swcfg_pkg::A_IRQ_PIN: rdata_next = irq_pin_mask_reg;
          swcfg_pkg::A_SETUP_A: rdata_next = switch_setup_reg_a;
          swcfg_pkg::A_SETUP_B: rdata_next = switch_setup_reg_b;
          default: begin
          end
        endcase
      end
      for (int p = 0; p < swcfg_pkg::NPORT; p++) begin
        if (port_idx == 4'(p + 1)) begin
          if (LINK.we) begin
            if (port_off == swcfg_pkg::O_ADV_UPPER) begin
              // writes that would enable the high level are dropped on a port whose ability flag is 0
              adv_abl_next[p] = LINK.wdata[swcfg_pkg::B_ADV_ABL]
                                & hv_tx_ability_flag[p];
              adv_req_next[p] = LINK.wdata[swcfg_pkg::B_ADV_REQ]
                                & hv_tx_ability_flag[p];
            end else if (port_off == swcfg_pkg::O_AN_CTRL) begin
              an_en_next[p] = LINK.wdata[swcfg_pkg::B_AN_EN];
            end
          end else begin
            // the ability flag has no register write path; only RESET_N or a soft reset clears it and relatches it from the strap
            if (port_off == swcfg_pkg::O_PMA_STAT) begin
              rdata_next[swcfg_pkg::B_HV_FLAG] = hv_tx_ability_flag[p];
            end else if (port_off == swcfg_pkg::O_ADV_UPPER) begin
              rdata_next[swcfg_pkg::B_ADV_ABL] = adv_hv_ability_bit[p];
              rdata_next[swcfg_pkg::B_ADV_REQ] = adv_hv_request_bit[p];
            end else if (port_off == swcfg_pkg::O_AN_CTRL) begin
              rdata_next[swcfg_pkg::B_AN_EN] = an_en_reg[p];
            end
          end
        end
      end
    end
    if (soft_rst_reg) begin
      irq_source_mask_next = swcfg_pkg::RST_IRQ_MASK;
      irq_pin_mask_next = swcfg_pkg::RST_IRQ_MASK;
      switch_setup_a_next = swcfg_pkg::RST_SETUP_A;
      switch_setup_b_next = swcfg_pkg::RST_SETUP_B;
      adv_abl_next = 2'h0;
      adv_req_next = 2'h0;
      an_en_next = '1;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_source_mask_reg <= swcfg_pkg::RST_IRQ_MASK;
      irq_pin_mask_reg <= swcfg_pkg::RST_IRQ_MASK;
      switch_setup_reg_a <= swcfg_pkg::RST_SETUP_A;
      switch_setup_reg_b <= swcfg_pkg::RST_SETUP_B;
      adv_hv_ability_bit <= 2'h0;
      adv_hv_request_bit <= 2'h0;
      an_en_reg <= '1;
      soft_rst_reg <= 1'b0;
      ack_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end else if (CE) begin
      irq_source_mask_reg <= irq_source_mask_next;
      irq_pin_mask_reg <= irq_pin_mask_next;
      switch_setup_reg_a <= switch_setup_a_next;
      switch_setup_reg_b <= switch_setup_b_next;
      adv_hv_ability_bit <= adv_abl_next;
      adv_hv_request_bit <= adv_req_next;
      an_en_reg <= an_en_next;
      soft_rst_reg <= soft_rst_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // negotiated transmit level
  // ----------------------------------------------------------------
  logic [1:0] level_reg, level_next;

  // high level only when both sides are able and one of them asks
  always_comb begin
    level_next = level_reg;
    for (int p = 0; p < swcfg_pkg::NPORT; p++) begin
      if (!an_en_reg[p] || !adv_hv_ability_bit[p]) begin
        level_next[p] = 1'b0;
      end else if (AN_DONE[p]) begin
        level_next[p] = LP_ABL[p] & (adv_hv_request_bit[p] | LP_REQ[p]);
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      level_reg <= 2'h0;
    end else if (CE) begin
      level_reg <= level_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign LINK.ack = ack_reg;
  assign LINK.rdata = rdata_reg;
  assign SETUP_DONE = switch_setup_reg_a[swcfg_pkg::B_SETUP_DONE];
  assign CHUNK_SIZE = switch_setup_reg_a[swcfg_pkg::B_CHUNK_LO +: 2];
  assign CUT_THROUGH = switch_setup_reg_a[swcfg_pkg::B_CUT_THRU];
  assign PORT1_UNKNOWN_TO_PORT2_EN = switch_setup_reg_b[swcfg_pkg::B_P1_TO_P2];
  assign PORT2_UNKNOWN_TO_PORT1_EN = switch_setup_reg_b[swcfg_pkg::B_P2_TO_P1];
  assign PORT1_UNKNOWN_TO_HOST_EN = switch_setup_reg_b[swcfg_pkg::B_P1_TO_HOST];
  assign PORT2_UNKNOWN_TO_HOST_EN = switch_setup_reg_b[swcfg_pkg::B_P2_TO_HOST];
  assign IRQ_SOURCE_MASK = irq_source_mask_reg;
  assign IRQ_PIN_MASK = irq_pin_mask_reg;
  assign HV_TX_ABILITY = hv_tx_ability_flag;
  assign ADV_HV_ABILITY = adv_hv_ability_bit;
  assign ADV_HV_REQUEST = adv_hv_request_bit;
  assign AN_ENABLE = an_en_reg;
  assign TX_LEVEL_HIGH = level_reg;
endmodule : swcfg_device

//--- common/swcfg_pkg.sv
// constants shared by the switch setup / transmit level device end and its host end
// assumes one 50 MHz clock shared by both ends
package swcfg_pkg;
  // ----------------------------------------------------------------
  // link widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int NPORT = 2;

  // ----------------------------------------------------------------
  // device register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] A_IRQ_SRC = 8'h00;
  localparam logic [7:0] A_IRQ_PIN = 8'h01;
  localparam logic [7:0] A_SETUP_A = 8'h02;
  localparam logic [7:0] A_SETUP_B = 8'h03;
  localparam logic [7:0] A_PORT_BASE = 8'h10;
  localparam logic [7:0] A_PORT_STRIDE = 8'h10;
  localparam logic [3:0] O_PMA_STAT = 4'h0;
  localparam logic [3:0] O_ADV_UPPER = 4'h1;
  localparam logic [3:0] O_AN_CTRL = 4'h2;

  // ----------------------------------------------------------------
  // device fields and reset values
  // ----------------------------------------------------------------
  localparam int B_SETUP_DONE = 0;
  localparam int B_CHUNK_LO = 1;
  localparam int B_CUT_THRU = 3;
  localparam int B_SOFT_RST = 15;
  localparam int B_P1_TO_P2 = 0;
  localparam int B_P2_TO_P1 = 1;
  localparam int B_P1_TO_HOST = 2;
  localparam int B_P2_TO_HOST = 3;
  localparam int B_HV_FLAG = 11;
  localparam int B_ADV_ABL = 12;
  localparam int B_ADV_REQ = 13;
  localparam int B_AN_EN = 12;
  localparam logic [15:0] RST_IRQ_MASK = 16'hffff;
  localparam logic [15:0] RST_SETUP_A = 16'h0000;
  localparam logic [15:0] RST_SETUP_B = 16'h0000;
  localparam logic [2:0] STRAP_SETTLE = 3'h3;

  // ----------------------------------------------------------------
  // host APB map
  // ----------------------------------------------------------------
  localparam logic [7:0] H_CMD = 8'h00;
  localparam logic [7:0] H_WDATA = 8'h04;
  localparam logic [7:0] H_RDATA = 8'h08;
  localparam logic [7:0] H_STATUS = 8'h0c;
  localparam int B_CMD_WR = 8;
  localparam int B_CMD_GO = 9;
  localparam int B_ST_BUSY = 0;
  localparam int B_ST_DONE = 1;

  typedef enum logic [0:0] {
    H_IDLE = 1'b0,
    H_BUSY = 1'b1
  } host_state_t;
endpackage : swcfg_pkg

//--- common/swcfg_link.sv
// register access link between the host end and the device end
// assumes both ends share one clock; the bench joins them
`timescale 1ns/1ps
interface swcfg_link;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic ack;
  logic [15:0] rdata;
  modport dev (input req, input we, input addr, input wdata, output ack, output rdata);
  modport host (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface : swcfg_link

//--- hw/swcfg_host.sv
// host end: APB-programmed command engine that issues link register accesses
// assumes the device end answers every request with one ack pulse
`timescale 1ns/1ps
module swcfg_host (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CE,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // link to device
  swcfg_link.host LINK
);
  // ----------------------------------------------------------------
  // command engine and APB registers
  // ----------------------------------------------------------------
  swcfg_pkg::host_state_t state_reg, state_next;
  logic [7:0] addr_reg, addr_next;
  logic we_reg, we_next;
  logic [15:0] wdata_reg, wdata_next;
  logic [15:0] rdata_reg, rdata_next;
  logic done_reg, done_next;
  logic [31:0] prdata_reg, prdata_next;
  logic setup, wr_acc, mapped;

  assign setup = PSEL && !PENABLE;
  assign wr_acc = PSEL && PENABLE && PWRITE;
  assign mapped = (PADDR == swcfg_pkg::H_CMD) || (PADDR == swcfg_pkg::H_WDATA)
                  || (PADDR == swcfg_pkg::H_RDATA) || (PADDR == swcfg_pkg::H_STATUS);

  always_comb begin
    state_next = state_reg;
    addr_next = addr_reg;
    we_next = we_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    done_next = done_reg;
    prdata_next = prdata_reg;
    if (wr_acc && PADDR == swcfg_pkg::H_STATUS && PWDATA[swcfg_pkg::B_ST_DONE]) begin
      done_next = 1'b0;
    end
    case (state_reg)
      swcfg_pkg::H_IDLE: begin
        // a command is frozen while it runs, so CMD writes only land when idle
        if (wr_acc && PADDR == swcfg_pkg::H_CMD) begin
          addr_next = PWDATA[7:0];
          we_next = PWDATA[swcfg_pkg::B_CMD_WR];
          if (PWDATA[swcfg_pkg::B_CMD_GO]) begin
            state_next = swcfg_pkg::H_BUSY;
          end
        end
        if (wr_acc && PADDR == swcfg_pkg::H_WDATA) begin
          wdata_next = PWDATA[15:0];
        end
      end
      swcfg_pkg::H_BUSY: begin
        if (LINK.ack) begin
          state_next = swcfg_pkg::H_IDLE;
          done_next = 1'b1;
          if (!we_reg) begin
            rdata_next = LINK.rdata;
          end
        end
      end
      default: state_next = swcfg_pkg::H_IDLE;
    endcase
    // read data is staged in the setup cycle so the access needs no wait
    if (setup) begin
      case (PADDR)
        swcfg_pkg::H_CMD: prdata_next = {23'h0, we_reg, addr_reg};
        swcfg_pkg::H_WDATA: prdata_next = {16'h0, wdata_reg};
        swcfg_pkg::H_RDATA: prdata_next = {16'h0, rdata_reg};
        swcfg_pkg::H_STATUS: prdata_next = {30'h0, done_reg, state_reg == swcfg_pkg::H_BUSY};
        default: prdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= swcfg_pkg::H_IDLE;
      addr_reg <= 8'h00;
      we_reg <= 1'b0;
      wdata_reg <= 16'h0000;
      rdata_reg <= 16'h0000;
      done_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else if (CE) begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      we_reg <= we_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      done_reg <= done_next;
      prdata_reg <= prdata_next;
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign LINK.req = (state_reg == swcfg_pkg::H_BUSY);
  assign LINK.we = we_reg;
  assign LINK.addr = addr_reg;
  assign LINK.wdata = wdata_reg;
endmodule : swcfg_host

//--- verif/swcfg_props.sv
// checker for the link between host end and device end, plus the advertisement outputs
// assumes one clock and CE held high; the bench instantiates it beside the link
`timescale 1ns/1ps
module swcfg_props (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // link
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic ack,
  // device side
  input wire logic [1:0] LP_ABL,
  input wire logic [1:0] LP_REQ,
  input wire logic [1:0] AN_DONE,
  input wire logic SETUP_DONE,
  input wire logic [1:0] HV_TX_ABILITY,
  input wire logic [1:0] ADV_HV_ABILITY,
  input wire logic [1:0] ADV_HV_REQUEST,
  input wire logic [1:0] AN_ENABLE,
  input wire logic [1:0] TX_LEVEL_HIGH
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // ----------------------------------------------------------------
  // cycles since the last soft reset request
  // ----------------------------------------------------------------
  logic [3:0] age_reg;
  logic [3:0] age_next;
  logic soft_hit;
  logic [1:0] want_hi;
  assign soft_hit = req && !ack && we && addr == swcfg_pkg::A_SETUP_A
                    && wdata[swcfg_pkg::B_SOFT_RST];
  assign want_hi = LP_ABL & (ADV_HV_REQUEST | LP_REQ);
  always_comb begin
    age_next = age_reg;
    if (soft_hit) begin
      age_next = 4'h0;
    end else if (age_reg != 4'hf) begin
      age_next = age_reg + 4'h1;
    end
  end
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      age_reg <= 4'h0;
    end else begin
      age_reg <= age_next;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sequence s_take; req && !ack; endsequence
  sequence s_done_wr;
    s_take ##0 (we && addr == swcfg_pkg::A_SETUP_A && wdata[swcfg_pkg::B_SETUP_DONE]);
  endsequence
  property p_ack_after; s_take |=> ack; endproperty
  property p_ack_one; ack |=> !ack; endproperty
  property p_setup_done; s_done_wr |=> SETUP_DONE; endproperty
  property p_abl_gated; (ADV_HV_ABILITY & ~HV_TX_ABILITY) == 2'b00; endproperty
  property p_req_gated; (ADV_HV_REQUEST & ~HV_TX_ABILITY) == 2'b00; endproperty
  property p_lvl_low; (ADV_HV_ABILITY == 2'b00) [*2] |-> TX_LEVEL_HIGH == 2'b00; endproperty
  property p_lvl_done;
    AN_ENABLE[0] && ADV_HV_ABILITY[0] && AN_DONE[0] ##1 ADV_HV_ABILITY[0]
      |-> TX_LEVEL_HIGH[0] == $past(want_hi[0]);
  endproperty
  property p_hv_hold; $changed(HV_TX_ABILITY) |-> age_reg < 4'hc; endproperty
  property p_an_default; $rose(RESET_N) |-> AN_ENABLE == 2'b11; endproperty
  a_ack_after: assert property (p_ack_after) else $error("ack missing after take");
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  a_setup_done: assert property (p_setup_done) else $error("setup done not set");
  a_abl_gated: assert property (p_abl_gated) else $error("ability bit without flag");
  a_req_gated: assert property (p_req_gated) else $error("request bit without flag");
  a_lvl_low: assert property (p_lvl_low) else $error("high level without ability");
  a_lvl_done: assert property (p_lvl_done) else $error("negotiated level wrong");
  a_hv_hold: assert property (p_hv_hold) else $error("ability flag moved");
  a_an_default: assert property (p_an_default) else $error("negotiation off at reset");
endmodule : swcfg_props

//--- verif/switch_init_tx_level_cfg_tb.sv
// self-checking bench: host end and device end joined by the link, driven over APB
// assumes the package constants and a 50 MHz clock
`timescale 1ns/1ps
module switch_init_tx_level_cfg_tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic last_err = 1'b0;
  logic [1:0] strap_n = 2'b10;
  logic [1:0] lp_abl = 2'b00;
  logic [1:0] lp_req = 2'b00;
  logic [1:0] an_done = 2'b00;
  logic done;
  logic cut;
  logic [1:0] chunk;
  logic [3:0] unk;
  logic [15:0] isrc;
  logic [15:0] ipin;
  logic [1:0] hv, abl, rq, anen, lvl;
  logic [31:0] seed = 32'h56e1d184;
  int fails = 0;
  int samples_checked = 0;
  always #10 clk = ~clk;
  swcfg_link link();
  swcfg_host i_swcfg_host (.CLK(clk), .RESET_N(reset_n), .CE(1'b1), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .LINK(link));
  swcfg_device i_swcfg_device (.CLK(clk), .RESET_N(reset_n), .CE(1'b1), .LINK(link),
    .TX_LEVEL_STRAP_N(strap_n), .LP_ABL(lp_abl), .LP_REQ(lp_req), .AN_DONE(an_done),
    .SETUP_DONE(done), .CHUNK_SIZE(chunk), .CUT_THROUGH(cut),
    .PORT1_UNKNOWN_TO_PORT2_EN(unk[0]), .PORT2_UNKNOWN_TO_PORT1_EN(unk[1]),
    .PORT1_UNKNOWN_TO_HOST_EN(unk[2]), .PORT2_UNKNOWN_TO_HOST_EN(unk[3]),
    .IRQ_SOURCE_MASK(isrc), .IRQ_PIN_MASK(ipin), .HV_TX_ABILITY(hv), .ADV_HV_ABILITY(abl),
    .ADV_HV_REQUEST(rq), .AN_ENABLE(anen), .TX_LEVEL_HIGH(lvl));
  swcfg_props i_swcfg_props (.CLK(clk), .RESET_N(reset_n), .req(link.req), .we(link.we),
    .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .LP_ABL(lp_abl), .LP_REQ(lp_req),
    .AN_DONE(an_done), .SETUP_DONE(done), .HV_TX_ABILITY(hv), .ADV_HV_ABILITY(abl),
    .ADV_HV_REQUEST(rq), .AN_ENABLE(anen), .TX_LEVEL_HIGH(lvl));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [7:0] padr(int p, logic [3:0] o);
    return swcfg_pkg::A_PORT_BASE + 8'(p) * swcfg_pkg::A_PORT_STRIDE + {4'h0, o};
  endfunction : padr
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic conclude();
    if (fails == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // one device access through the host command engine
  task automatic dev(input logic w, input logic [7:0] a, input logic [15:0] d,
                     output logic [15:0] r);
    logic [31:0] t;
    int n;
    n = 0;
    apb(1'b1, swcfg_pkg::H_WDATA, {16'h0, d}, t);
    apb(1'b1, swcfg_pkg::H_CMD, {22'h0, 1'b1, w, a}, t);
    do begin
      apb(1'b0, swcfg_pkg::H_STATUS, 32'h0, t);
      n++;
    end while (t[swcfg_pkg::B_ST_DONE] !== 1'b1 && n < 20);
    chk("link done", 32'h1, {31'h0, t[swcfg_pkg::B_ST_DONE]});
    apb(1'b0, swcfg_pkg::H_RDATA, 32'h0, t);
    r = t[15:0];
    apb(1'b1, swcfg_pkg::H_STATUS, 32'h2, t);
  endtask : dev
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] rd, v;
    logic [31:0] t;
    logic [1:0] fl, la, lq;
    logic ea, er;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge clk);
    fl = ~strap_n;
    chk("hv flag", {30'h0, fl}, {30'h0, hv});
    chk("an enable", 32'h3, {30'h0, anen});
    chk("irq masks", {2{swcfg_pkg::RST_IRQ_MASK}}, {isrc, ipin});
    for (int i = 0; i < 2; i++) begin
      v = 16'(rnd());
      dev(1'b1, swcfg_pkg::A_IRQ_SRC + 8'(i), v, rd);
      dev(1'b0, swcfg_pkg::A_IRQ_SRC + 8'(i), 16'h0, rd);
      chk("irq mask read", {16'h0, v}, {16'h0, rd});
      chk("irq mask out", {16'h0, v}, {16'h0, i == 0 ? isrc : ipin});
    end
    for (int i = 0; i < 4; i++) begin
      dev(1'b1, swcfg_pkg::A_SETUP_B, 16'h1 << i, rd);
      chk("unknown fwd", 32'h1 << i, {28'h0, unk});
    end
    v = (16'(rnd()) & 16'h000e) | 16'h0001;
    dev(1'b1, swcfg_pkg::A_SETUP_A, v, rd);
    chk("setup a", {28'h0, v[3:0]}, {28'h0, cut, chunk, done});
    for (int p = 0; p < 2; p++) begin
      dev(1'b1, padr(p, swcfg_pkg::O_PMA_STAT), {4'h0, !fl[p], 11'h0}, rd);
      dev(1'b0, padr(p, swcfg_pkg::O_PMA_STAT), 16'h0, rd);
      chk("pma flag", {31'h0, fl[p]}, {31'h0, rd[swcfg_pkg::B_HV_FLAG]});
      for (int k = 0; k < 8; k++) begin
        v = 16'(rnd()) & 16'h3000;
        dev(1'b1, padr(p, swcfg_pkg::O_ADV_UPPER), v, rd);
        ea = v[swcfg_pkg::B_ADV_ABL] & fl[p];
        er = v[swcfg_pkg::B_ADV_REQ] & fl[p];
        chk("adv ability", {31'h0, ea}, {31'h0, abl[p]});
        chk("adv request", {31'h0, er}, {31'h0, rq[p]});
        la = 2'(rnd());
        lq = 2'(rnd());
        lp_abl <= la;
        lp_req <= lq;
        an_done <= 2'b01 << p;
        @(posedge clk);
        an_done <= 2'b00;
        repeat (2) @(posedge clk);
        chk("tx level", {31'h0, ea & la[p] & (er | lq[p])}, {31'h0, lvl[p]});
      end
    end
    // negotiation switched off on port 1: the level must stay low whatever the partner says
    dev(1'b1, padr(0, swcfg_pkg::O_AN_CTRL), 16'h0000, rd);
    dev(1'b0, padr(0, swcfg_pkg::O_AN_CTRL), 16'h0, rd);
    chk("an ctrl read", 32'h0, {16'h0, rd});
    lp_abl <= 2'b11;
    lp_req <= 2'b11;
    an_done <= 2'b01;
    @(posedge clk);
    an_done <= 2'b00;
    repeat (2) @(posedge clk);
    chk("level an off", 32'h0, {30'h0, lvl});
    dev(1'b1, padr(0, swcfg_pkg::O_AN_CTRL), 16'h1000, rd);
    chk("an enable again", 32'h3, {30'h0, anen});
    strap_n <= ~strap_n;
    repeat (8) @(posedge clk);
    chk("hv held", {30'h0, fl}, {30'h0, hv});
    dev(1'b1, swcfg_pkg::A_SETUP_A, 16'h8000, rd);
    repeat (10) @(posedge clk);
    fl = ~strap_n;
    chk("hv relatched", {30'h0, fl}, {30'h0, hv});
    chk("adv cleared", 32'h0, {28'h0, abl, rq});
    chk("mask reset", {16'h0, swcfg_pkg::RST_IRQ_MASK}, {16'h0, isrc});
    chk("an reset", 32'h3, {30'h0, anen});
    dev(1'b1, padr(1, swcfg_pkg::O_ADV_UPPER), 16'h3000, rd);
    chk("adv relatched", {30'h0, fl[1], fl[1]}, {30'h0, abl[1], rq[1]});
    // bus error only on an unmapped host address, which reads as zero
    apb(1'b0, swcfg_pkg::H_WDATA, 32'h0, t);
    chk("apb err mapped", 32'h0, {31'h0, last_err});
    apb(1'b0, swcfg_pkg::H_STATUS + 8'h10, 32'h0, t);
    chk("apb err unmapped", 32'h1, {31'h0, last_err});
    chk("apb unmapped rdata", 32'h0, t);
    conclude();
  end
  // watchdog: the full sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    conclude();
  end
endmodule : switch_init_tx_level_cfg_tb
